// file: rmdfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side of the four-wire port, mode 3: clock idles high
module rmdfc_host_model #(
  parameter int WAIT_CYC = 100
) (
  input  wire logic clk,
  output var  logic ncs_n,
  output var  logic sclk,
  output var  logic mosi,
  input  wire logic miso
);
  logic [7:0] rx;
  initial
  begin
    ncs_n = 1'b1;
    sclk  = 1'b1;
    mosi  = 1'b0;
  end
  task automatic xbyte(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b0;
      mosi = tx[i];
      #62.5;
      sclk = 1'b1;
      rx[i] = miso;
      #62.5;
    end
  endtask
  task automatic sel;
    ncs_n = 1'b0;
    #62.5;
  endtask
  // Released data line flips so a stale bit is never mistaken for data
  task automatic desel;
    ncs_n = 1'b1;
    mosi  = ~mosi;
    #250;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    sel();
    xbyte({1'b1, a});
    xbyte(d);
    desel();
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    sel();
    xbyte({1'b0, a});
    xbyte(8'h00);
    d = rx;
    desel();
  endtask
  task automatic download(input int n);
    sel();
    xbyte({1'b1, rmdfc_pkg::ADDR_FW_TRIGGER});
    xbyte(rmdfc_pkg::CODE_FW_DOWNLOAD);
    xbyte({1'b1, rmdfc_pkg::ADDR_FW_DATA});
    for (int i = 0; i < n; i++)
      xbyte(8'(i * 7 + 17));
    desel();
  endtask
  task automatic settle;
    repeat (WAIT_CYC) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: rmdfc_pkg.sv
// Notes on behaviour
// - Frame capture write stores next whole frame into firmware RAM, halting navigation.
// - Trigger register write starts firmware download or RAM CRC check, by value.
// - CRC check halts navigation; controller stays off the serial port meanwhile.
// - Code 0x15 written to the trigger register starts the CRC check.
// - Finished CRC appears split over data lower and data upper registers.
// - Run idle time before first rest is run count times 10ms.
// - Run downshift interval is timed from the system clock.
// - First rest frame period is (count plus one) times 10ms.
// - First to second rest idle time is count times 16 first-rest frames.
// - Second rest frame period is (count plus one) times 10ms.
// - Second to third rest idle time is count times 32 second-rest frames.
// - Third rest frame period is (count plus one) times 10ms.
// - Rest periods and rest downshifts count on the 100Hz hibernate tick.
// - Rest states are entered only while the rest enable bit is set, or when forced by the config force field.
// - Idle steps run to rest one, two, three; motion returns to run.
package rmdfc_pkg;

  // Register offsets
  localparam logic [6:0] ADDR_CONFIG      = 7'h10;
  localparam logic [6:0] ADDR_FRAME_CAP   = 7'h12;
  localparam logic [6:0] ADDR_FW_TRIGGER  = 7'h13;
  localparam logic [6:0] ADDR_RUN_IDLE    = 7'h14;
  localparam logic [6:0] ADDR_R1_PERIOD   = 7'h15;
  localparam logic [6:0] ADDR_R1_IDLE     = 7'h16;
  localparam logic [6:0] ADDR_R2_PERIOD   = 7'h17;
  localparam logic [6:0] ADDR_R2_IDLE     = 7'h18;
  localparam logic [6:0] ADDR_R3_PERIOD   = 7'h19;
  localparam logic [6:0] ADDR_DATA_LOWER  = 7'h25;
  localparam logic [6:0] ADDR_DATA_UPPER  = 7'h26;
  localparam logic [6:0] ADDR_STATUS      = 7'h27;
  localparam logic [6:0] ADDR_FW_DATA     = 7'h62;

  // Reset values
  localparam logic [7:0] RST_CONFIG       = 8'h00;
  localparam logic [7:0] RST_RUN_IDLE     = 8'h32;
  localparam logic [7:0] RST_R1_PERIOD    = 8'h01;
  localparam logic [7:0] RST_R1_IDLE      = 8'h1f;
  localparam logic [7:0] RST_R2_PERIOD    = 8'h09;
  localparam logic [7:0] RST_R2_IDLE      = 8'hbc;
  localparam logic [7:0] RST_R3_PERIOD    = 8'h31;

  // Config field positions
  localparam int CFG_FORCE_LSB = 6;
  localparam int CFG_REST_EN   = 5;

  // Trigger codes
  localparam logic [7:0] CODE_CRC_CHECK   = 8'h15;
  localparam logic [7:0] CODE_FW_DOWNLOAD = 8'h1d;

  // Serial frame: address MSB set means write
  localparam int SPI_WRITE_BIT = 7;

  // Rest idle multipliers as shift amounts
  localparam int R1_IDLE_SHIFT = 4;
  localparam int R2_IDLE_SHIFT = 5;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYCLES   = (TICK_MS * 1000000) / CLK_PERIOD_NS;

  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  // One-hot power states
  typedef enum logic [3:0] {
    PS_RUN   = 4'b0001,
    PS_FIRST_LOW  = 4'b0010,
    PS_SECOND_LOW = 4'b0100,
    PS_THIRD_LOW  = 4'b1000
  } rmdfc_state_t;

endpackage

// file: rmdfc_tick.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the system clock down to one pulse per period
module rmdfc_tick #(
  parameter int CYCLES = 1250000
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clear,
  output var  logic tick
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_reg;
  logic          tick_reg;
  wire           wrap = (cnt_reg == CW'(CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= (clear || wrap) ? '0 : cnt_reg + 1'b1;
      tick_reg <= wrap && !clear;
    end
  end

  assign tick = tick_reg;

endmodule
`default_nettype wire

// file: rmdfc_top.sv
`timescale 1ns/1ps
`default_nettype none
module rmdfc_top #(
  parameter int TICK_CYCLES  = rmdfc_pkg::TICK_CYCLES,
  parameter int FW_RAM_DEPTH = 3072,
  parameter int FRAME_PIXELS = 900
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ncs_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  output var  logic       miso,
  output var  logic       miso_oe,
  input  wire logic       motion_det,
  input  wire logic       frame_start,
  input  wire logic       pixel_valid,
  input  wire logic [7:0] pixel_data,
  output var  logic [3:0] power_state,
  output var  logic       rest_frame_strobe,
  output var  logic       nav_halt,
  output var  logic       crc_busy
);

  localparam int AW = $clog2(FW_RAM_DEPTH);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
      r = r[15] ? ((r << 1) ^ rmdfc_pkg::CRC_POLY) : (r << 1);
    return r;
  endfunction

  // Serial pins cross from the controller's domain
  logic [2:0] sclk_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic [1:0] ncs_sync_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_sync_reg <= 3'h7;
      mosi_sync_reg <= 2'h0;
      ncs_sync_reg  <= 2'h3;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi};
      ncs_sync_reg  <= {ncs_sync_reg[0], ncs_n};
    end
  end

  wire sel      = !ncs_sync_reg[1];
  wire sclk_ris = sel && sclk_sync_reg[1] && !sclk_sync_reg[2];
  wire sclk_fal = sel && !sclk_sync_reg[1] && sclk_sync_reg[2];

  // Byte assembly: first byte address, second data
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       data_phase_reg;
  logic [7:0] addr_reg;
  logic [7:0] tx_reg;
  logic       miso_reg;
  logic       miso_oe_reg;

  wire       byte_done = sclk_ris && (bit_cnt_reg == 3'h7);
  wire [7:0] rx_byte   = {shift_reg[6:0], mosi_sync_reg[1]};
  wire       is_write  = addr_reg[rmdfc_pkg::SPI_WRITE_BIT];
  wire [6:0] reg_addr  = addr_reg[6:0];
  wire       addr_done = byte_done && !data_phase_reg;

  // Control registers
  logic [7:0] cfg_reg;
  logic [7:0] run_idle_reg;
  logic [7:0] r1_period_reg;
  logic [7:0] r1_idle_reg;
  logic [7:0] r2_period_reg;
  logic [7:0] r2_idle_reg;
  logic [7:0] r3_period_reg;
  logic [15:0] crc_result_reg;
  logic        fw_loaded_reg;
  logic        dl_mode_reg;
  logic        crc_busy_reg;
  logic        nav_halt_reg;
  rmdfc_pkg::rmdfc_state_t state_reg;

  wire       wr_stb    = byte_done && data_phase_reg && is_write && !crc_busy_reg;
  wire       burst     = (reg_addr == rmdfc_pkg::ADDR_FW_DATA) && dl_mode_reg;
  wire [7:0] shift_reg_next_data = rx_byte;
  wire wr_cap     = wr_stb && (reg_addr == rmdfc_pkg::ADDR_FRAME_CAP);
  wire wr_trigger = wr_stb && (reg_addr == rmdfc_pkg::ADDR_FW_TRIGGER);
  wire wr_fw_data = wr_stb && (reg_addr == rmdfc_pkg::ADDR_FW_DATA) && dl_mode_reg;
  wire crc_start  = wr_trigger && (shift_reg_next_data == rmdfc_pkg::CODE_CRC_CHECK);
  wire dl_start   = wr_trigger && (shift_reg_next_data == rmdfc_pkg::CODE_FW_DOWNLOAD);

  // Read data for the selected address; write-only and unmapped read zero
  wire [7:0] rd_mux =
    (reg_addr == rmdfc_pkg::ADDR_CONFIG)     ? cfg_reg :
    (reg_addr == rmdfc_pkg::ADDR_RUN_IDLE)   ? run_idle_reg :
    (reg_addr == rmdfc_pkg::ADDR_R1_PERIOD)  ? r1_period_reg :
    (reg_addr == rmdfc_pkg::ADDR_R1_IDLE)    ? r1_idle_reg :
    (reg_addr == rmdfc_pkg::ADDR_R2_PERIOD)  ? r2_period_reg :
    (reg_addr == rmdfc_pkg::ADDR_R2_IDLE)    ? r2_idle_reg :
    (reg_addr == rmdfc_pkg::ADDR_R3_PERIOD)  ? r3_period_reg :
    (reg_addr == rmdfc_pkg::ADDR_DATA_LOWER) ? crc_result_reg[7:0] :
    (reg_addr == rmdfc_pkg::ADDR_DATA_UPPER) ? crc_result_reg[15:8] :
    (reg_addr == rmdfc_pkg::ADDR_STATUS)     ? {fw_loaded_reg, dl_mode_reg, crc_busy_reg, nav_halt_reg, state_reg} :
    8'h00;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt_reg    <= 3'h0;
      shift_reg      <= 8'h00;
      data_phase_reg <= 1'b0;
      addr_reg       <= 8'h00;
      tx_reg         <= 8'h00;
      miso_reg       <= 1'b0;
      miso_oe_reg    <= 1'b0;
    end
    else if (!sel)
    begin
      bit_cnt_reg    <= 3'h0;
      data_phase_reg <= 1'b0;
      miso_oe_reg    <= 1'b0;
    end
    else
    begin
      miso_oe_reg <= 1'b1;
      if (sclk_ris)
      begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        shift_reg   <= rx_byte;
      end
      if (addr_done)
      begin
        addr_reg       <= rx_byte;
        data_phase_reg <= 1'b1;
        tx_reg         <= 8'h00;
      end
      else if (byte_done)
        data_phase_reg <= burst;
      // Read data is fetched once the address is known
      if (sclk_ris && data_phase_reg && (bit_cnt_reg == 3'h0) && !is_write)
        tx_reg <= {rd_mux[6:0], 1'b0};
      else if (sclk_fal && data_phase_reg && !is_write)
        tx_reg <= {tx_reg[6:0], 1'b0};
      if (sclk_fal && data_phase_reg && !is_write)
        miso_reg <= (bit_cnt_reg == 3'h0) ? rd_mux[7] : tx_reg[7];
    end
  end

  // Firmware RAM
  logic [7:0]    fw_ram [FW_RAM_DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] crc_idx_reg;
  logic [15:0]   crc_acc_reg;
  logic          cap_armed_reg;
  logic          cap_run_reg;

  wire cap_wr  = cap_run_reg && pixel_valid;
  wire cap_end = cap_wr && (wr_ptr_reg == AW'(FRAME_PIXELS - 1));
  wire ram_we  = cap_wr || wr_fw_data;
  wire [7:0] ram_wd = cap_wr ? pixel_data : rx_byte;

  always_ff @(posedge clk)
  begin
    if (ram_we)
      fw_ram[wr_ptr_reg] <= ram_wd;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_reg       <= rmdfc_pkg::RST_CONFIG;
      run_idle_reg  <= rmdfc_pkg::RST_RUN_IDLE;
      r1_period_reg <= rmdfc_pkg::RST_R1_PERIOD;
      r1_idle_reg   <= rmdfc_pkg::RST_R1_IDLE;
      r2_period_reg <= rmdfc_pkg::RST_R2_PERIOD;
      r2_idle_reg   <= rmdfc_pkg::RST_R2_IDLE;
      r3_period_reg <= rmdfc_pkg::RST_R3_PERIOD;
    end
    else if (wr_stb)
    begin
      case (reg_addr)
        rmdfc_pkg::ADDR_CONFIG:    cfg_reg       <= rx_byte;
        rmdfc_pkg::ADDR_RUN_IDLE:  run_idle_reg  <= rx_byte;
        rmdfc_pkg::ADDR_R1_PERIOD: r1_period_reg <= rx_byte;
        rmdfc_pkg::ADDR_R1_IDLE:   r1_idle_reg   <= rx_byte;
        rmdfc_pkg::ADDR_R2_PERIOD: r2_period_reg <= rx_byte;
        rmdfc_pkg::ADDR_R2_IDLE:   r2_idle_reg   <= rx_byte;
        rmdfc_pkg::ADDR_R3_PERIOD: r3_period_reg <= rx_byte;
        default:                   cfg_reg       <= cfg_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg     <= '0;
      crc_idx_reg    <= '0;
      crc_acc_reg    <= rmdfc_pkg::CRC_INIT;
      crc_result_reg <= 16'h0000;
      crc_busy_reg   <= 1'b0;
      fw_loaded_reg  <= 1'b0;
      dl_mode_reg    <= 1'b0;
      cap_armed_reg  <= 1'b0;
      cap_run_reg    <= 1'b0;
      nav_halt_reg   <= 1'b0;
    end
    else
    begin
      if (wr_cap)
      begin
        cap_armed_reg <= 1'b1;
        nav_halt_reg  <= 1'b1;
        fw_loaded_reg <= 1'b0;
        dl_mode_reg   <= 1'b0;
      end
      else if (cap_armed_reg && frame_start)
      begin
        cap_armed_reg <= 1'b0;
        cap_run_reg   <= 1'b1;
        wr_ptr_reg    <= '0;
      end
      else if (cap_end)
        cap_run_reg <= 1'b0;
      else if (dl_start)
      begin
        dl_mode_reg   <= 1'b1;
        fw_loaded_reg <= 1'b0;
        wr_ptr_reg    <= '0;
      end
      // Download ends when the controller releases select
      else if (dl_mode_reg && !sel)
      begin
        dl_mode_reg   <= 1'b0;
        fw_loaded_reg <= 1'b1;
      end
      else if (crc_start)
      begin
        crc_busy_reg <= 1'b1;
        crc_idx_reg  <= '0;
        crc_acc_reg  <= rmdfc_pkg::CRC_INIT;
      end
      if (cap_wr || wr_fw_data)
        wr_ptr_reg <= (wr_ptr_reg == AW'(FW_RAM_DEPTH - 1)) ? wr_ptr_reg : wr_ptr_reg + 1'b1;
      if (crc_busy_reg)
      begin
        crc_acc_reg <= crc_byte(crc_acc_reg, fw_ram[crc_idx_reg]);
        crc_idx_reg <= crc_idx_reg + 1'b1;
        if (crc_idx_reg == AW'(FW_RAM_DEPTH - 1))
        begin
          crc_busy_reg   <= 1'b0;
          crc_result_reg <= crc_byte(crc_acc_reg, fw_ram[crc_idx_reg]);
        end
      end
    end
  end

  // Power mode timing
  wire        hib_tick;
  wire        run_tick;
  logic [7:0] run_ticks_reg;
  logic [7:0] frame_ticks_reg;
  logic [12:0] frames_reg;
  logic        strobe_reg;
  rmdfc_pkg::rmdfc_state_t state_next;

  wire [1:0] force_sel = cfg_reg[rmdfc_pkg::CFG_FORCE_LSB +: 2];
  wire       rest_en   = cfg_reg[rmdfc_pkg::CFG_REST_EN];
  // Navigation halt and CRC busy mask motion so capture or check cannot wake the part
  wire       motion    = motion_det && !nav_halt_reg && !crc_busy_reg;
  wire       retime    = motion || crc_busy_reg || (state_next != state_reg);

  wire [7:0] cur_period =
    (state_reg == rmdfc_pkg::PS_FIRST_LOW)  ? r1_period_reg :
    (state_reg == rmdfc_pkg::PS_SECOND_LOW) ? r2_period_reg : r3_period_reg;
  wire       frame_evt  = hib_tick && (state_reg != rmdfc_pkg::PS_RUN) && (frame_ticks_reg == cur_period);

  wire run_idle_hit = (run_ticks_reg >= run_idle_reg);
  wire r1_idle_hit  = (frames_reg >= {1'b0, r1_idle_reg, 4'h0});
  wire r2_idle_hit  = (frames_reg >= {r2_idle_reg, 5'h00});

  rmdfc_tick #(.CYCLES(TICK_CYCLES)) u_run_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (retime),
    .tick    (run_tick)
  );

  rmdfc_tick #(.CYCLES(TICK_CYCLES)) u_hib_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (1'b0),
    .tick    (hib_tick)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      rmdfc_pkg::PS_RUN:
        if (rest_en && run_idle_hit && !motion)
          state_next = rmdfc_pkg::PS_FIRST_LOW;
      rmdfc_pkg::PS_FIRST_LOW:
        if (motion || !rest_en)
          state_next = rmdfc_pkg::PS_RUN;
        else if (r1_idle_hit)
          state_next = rmdfc_pkg::PS_SECOND_LOW;
      rmdfc_pkg::PS_SECOND_LOW:
        if (motion || !rest_en)
          state_next = rmdfc_pkg::PS_RUN;
        else if (r2_idle_hit)
          state_next = rmdfc_pkg::PS_THIRD_LOW;
      rmdfc_pkg::PS_THIRD_LOW:
        if (motion || !rest_en)
          state_next = rmdfc_pkg::PS_RUN;
      default:
        state_next = rmdfc_pkg::PS_RUN;
    endcase
    // Forced rest holds the chosen state until released
    case (force_sel)
      2'h1:    state_next = rmdfc_pkg::PS_FIRST_LOW;
      2'h2:    state_next = rmdfc_pkg::PS_SECOND_LOW;
      2'h3:    state_next = rmdfc_pkg::PS_THIRD_LOW;
      default: state_next = state_next;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg       <= rmdfc_pkg::PS_RUN;
      run_ticks_reg   <= 8'h00;
      frame_ticks_reg <= 8'h00;
      frames_reg      <= 13'h0000;
      strobe_reg      <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      strobe_reg <= frame_evt;
      if (retime)
      begin
        run_ticks_reg <= 8'h00;
        frames_reg    <= 13'h0000;
      end
      else
      begin
        if (run_tick && !run_idle_hit)
          run_ticks_reg <= run_ticks_reg + 8'h01;
        if (frame_evt && (frames_reg != 13'h1fff))
          frames_reg <= frames_reg + 13'h0001;
      end
      if (state_next != state_reg)
        frame_ticks_reg <= 8'h00;
      else if (hib_tick)
        frame_ticks_reg <= frame_evt ? 8'h00 : frame_ticks_reg + 8'h01;
    end
  end

  assign miso              = miso_reg;
  assign miso_oe           = miso_oe_reg;
  assign power_state       = state_reg;
  assign rest_frame_strobe = strobe_reg;
  assign nav_halt          = nav_halt_reg;
  assign crc_busy          = crc_busy_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_crc_req;
    wr_trigger && (rx_byte == rmdfc_pkg::CODE_CRC_CHECK) && !cap_armed_reg && !cap_end && !dl_mode_reg;
  endsequence

  property p_crc_start;
    s_crc_req |=> crc_busy_reg ##1 crc_busy_reg;
  endproperty
  a_crc_start: assert property (p_crc_start) else $error("CRC check did not start");

  logic [15:0] crc_acc_reg_done;
  property p_crc_result;
    $fell(crc_busy_reg) |-> (crc_result_reg == crc_acc_reg_done);
  endproperty
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      crc_acc_reg_done <= 16'h0000;
    else if (crc_busy_reg && (crc_idx_reg == AW'(FW_RAM_DEPTH - 1)))
      crc_acc_reg_done <= crc_byte(crc_acc_reg, fw_ram[crc_idx_reg]);
  end
  a_crc_result: assert property (p_crc_result) else $error("CRC result not presented");

  property p_crc_quiet;
    crc_busy_reg |-> !wr_stb && (state_reg == $past(state_reg) || force_sel != 2'h0 || !rest_en);
  endproperty
  a_crc_quiet: assert property (p_crc_quiet) else $error("Activity during CRC check");

  property p_capture;
    wr_cap |=> nav_halt_reg && !fw_loaded_reg && cap_armed_reg;
  endproperty
  a_capture: assert property (p_capture) else $error("Frame capture not armed");

  sequence s_run_idle;
    (state_reg == rmdfc_pkg::PS_RUN) && rest_en && run_idle_hit && !motion && force_sel == 2'h0;
  endsequence

  property p_run_down;
    s_run_idle |=> (state_reg == rmdfc_pkg::PS_FIRST_LOW);
  endproperty
  a_run_down: assert property (p_run_down) else $error("Run did not step to first rest");

  property p_no_rest;
    (!rest_en && force_sel == 2'h0) |=> (state_reg == rmdfc_pkg::PS_RUN);
  endproperty
  a_no_rest: assert property (p_no_rest) else $error("Rest entered while disabled");

  property p_wake;
    ((state_reg != rmdfc_pkg::PS_RUN) && motion && force_sel == 2'h0) |=> (state_reg == rmdfc_pkg::PS_RUN);
  endproperty
  a_wake: assert property (p_wake) else $error("Motion did not wake to run");

  property p_r1_down;
    ((state_reg == rmdfc_pkg::PS_FIRST_LOW) && rest_en && !motion && r1_idle_hit && force_sel == 2'h0)
      |=> (state_reg == rmdfc_pkg::PS_SECOND_LOW);
  endproperty
  a_r1_down: assert property (p_r1_down) else $error("First rest did not step down");

  property p_frame;
    frame_evt |=> rest_frame_strobe ##1 !rest_frame_strobe;
  endproperty
  a_frame: assert property (p_frame) else $error("Rest frame strobe missing");

  property p_retime;
    motion |=> (run_ticks_reg == 8'h00) && (frames_reg == 13'h0000);
  endproperty
  a_retime: assert property (p_retime) else $error("Idle timer not restarted");

endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int T   = 20;
  localparam int DEP = 64;
  logic       clk, reset_n, motion_det, frame_start, pixel_valid;
  logic [7:0] pixel_data, v;
  logic [3:0] power_state;
  logic       miso, miso_oe, miso_w, rest_frame_strobe, nav_halt, crc_busy;
  wire logic  ncs_n, sclk, mosi;
  int         err_count = 0, num_checks = 0, cyc = 0, t0, t1, t2;
  logic [7:0] ram [DEP];
  logic [7:0] rst_v [6] = '{8'h32, 8'h01, 8'h1f, 8'h09, 8'hbc, 8'h31};
  logic [7:0] new_v [6] = '{8'h03, 8'h01, 8'h01, 8'h00, 8'h01, 8'h02};
  assign miso_w = miso_oe ? miso : cyc[0];
  rmdfc_top #(.TICK_CYCLES(T), .FW_RAM_DEPTH(DEP), .FRAME_PIXELS(16)) dut (
    .clk(clk), .reset_n(reset_n), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .motion_det(motion_det), .frame_start(frame_start), .pixel_valid(pixel_valid), .pixel_data(pixel_data),
    .power_state(power_state), .rest_frame_strobe(rest_frame_strobe), .nav_halt(nav_halt), .crc_busy(crc_busy));
  rmdfc_host_model #(.WAIT_CYC(100)) host (.clk(clk), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi), .miso(miso_w));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    num_checks++;
    if (g < lo || g > hi)
    begin
      err_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [6:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk(nm, {8'h00, e}, {8'h00, v});
  endtask
  task automatic wait_state(input logic [3:0] s, input int lim, output int t);
    for (int n = 0; n < lim && power_state !== s; n++)
      @(negedge clk);
    t = cyc;
    chk("power state", {12'h000, s}, {12'h000, power_state});
  endtask
  task automatic wait_strobe(output int t);
    for (int n = 0; n < 200 && rest_frame_strobe !== 1'b1; n++)
      @(negedge clk);
    t = cyc;
    @(negedge clk);
  endtask
  function automatic logic [15:0] crc16;
    logic [15:0] c;
    c = rmdfc_pkg::CRC_INIT;
    foreach (ram[i])
    begin
      c = c ^ {ram[i], 8'h00};
      for (int b = 0; b < 8; b++)
        c = c[15] ? ((c << 1) ^ rmdfc_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  task automatic crc_run;
    logic [7:0] lo, hi;
    host.wr(rmdfc_pkg::ADDR_FW_TRIGGER, rmdfc_pkg::CODE_CRC_CHECK);
    chk("crc busy", 16'h0001, {15'h0000, crc_busy});
    host.settle();
    chk("crc done", 16'h0000, {15'h0000, crc_busy});
    host.rd(rmdfc_pkg::ADDR_DATA_LOWER, lo);
    host.rd(rmdfc_pkg::ADDR_DATA_UPPER, hi);
    chk("crc value", crc16(), {hi, lo});
  endtask
  initial
  begin
    reset_n = 1'b0;
    motion_det = 1'b0;
    frame_start = 1'b0;
    pixel_valid = 1'b0;
    pixel_data = 8'h00;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 6; i++)
      rchk("reset value", 7'(rmdfc_pkg::ADDR_RUN_IDLE + i), rst_v[i]);
    for (int i = 0; i < 6; i++)
    begin
      host.wr(7'(rmdfc_pkg::ADDR_RUN_IDLE + i), new_v[i]);
      rchk("readback", 7'(rmdfc_pkg::ADDR_RUN_IDLE + i), new_v[i]);
    end
    rchk("write-only", rmdfc_pkg::ADDR_FW_TRIGGER, 8'h00);
    rchk("unmapped", 7'h7f, 8'h00);
    repeat (100) @(negedge clk);
    chk("rest disabled", 16'h0001, {12'h000, power_state});
    motion_det = 1'b1;
    host.wr(rmdfc_pkg::ADDR_CONFIG, 8'h20);
    @(negedge clk);
    motion_det = 1'b0;
    t0 = cyc;
    wait_state(4'b0010, 100, t1);
    chk_rng("run dwell", 2 * T, 3 * T + 3, t1 - t0);
    wait_strobe(t0);
    wait_strobe(t2);
    chk_rng("first rest frame", 2 * T, 2 * T, t2 - t0);
    wait_state(4'b0100, 700, t0);
    chk_rng("first rest dwell", 15 * 2 * T, 16 * 2 * T + 3, t0 - t1);
    wait_strobe(t1);
    wait_strobe(t2);
    chk_rng("second rest frame", T, T, t2 - t1);
    wait_state(4'b1000, 700, t1);
    chk_rng("second rest dwell", 31 * T, 32 * T + 3, t1 - t0);
    wait_strobe(t0);
    wait_strobe(t2);
    chk_rng("third rest frame", 3 * T, 3 * T, t2 - t0);
    repeat (200) @(negedge clk);
    chk("third rest held", 16'h0008, {12'h000, power_state});
    motion_det = 1'b1;
    @(negedge clk);
    chk("motion wakes", 16'h0001, {12'h000, power_state});
    rchk("status", rmdfc_pkg::ADDR_STATUS, 8'h01);
    host.download(DEP);
    rchk("loaded", rmdfc_pkg::ADDR_STATUS, 8'h81);
    foreach (ram[i])
      ram[i] = 8'(i * 7 + 17);
    crc_run();
    host.wr(rmdfc_pkg::ADDR_FRAME_CAP, 8'h5a);
    chk("nav halt", 16'h0001, {15'h0000, nav_halt});
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      pixel_valid = 1'b1;
      pixel_data = 8'hc0 + 8'(i);
      ram[i] = pixel_data;
      @(negedge clk);
    end
    pixel_valid = 1'b0;
    crc_run();
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk("halt cleared", 16'h0000, {15'h0000, nav_halt});
    results();
  end
  // Whole run is well under this span; a hang ends here
  initial
  begin
    #400000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
